// File: core/pbp_pkg.sv
// Shared constants and types for the primary-side bridge port
package pbp_pkg;
    localparam int AD_W = 32;
    localparam int CBE_W = 4;
    localparam int IDX_W = 6;
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;
    localparam logic [IDX_W-1:0] CFG_IDX_CMD = 6'h01;
    localparam logic [IDX_W-1:0] CFG_IDX_BCTL = 6'h0F;
    localparam int CMD_PERR_EN_BIT = 6;
    localparam int CMD_SERR_EN_BIT = 8;
    localparam int BCTL_SEC_RST_BIT = 5;
    localparam int BCTL_SERR_FWD_BIT = 6;
    localparam int STAT_DET_PAR_BIT = 15;
    localparam int STAT_SIG_SERR_BIT = 14;
    localparam int STAT_MABORT_BIT = 13;
    localparam logic [15:0] STAT_MASK = 16'hE000;
    localparam logic [15:0] CMD_RST = 16'h0000;
    localparam logic [15:0] BCTL_RST = 16'h0000;
    localparam logic [15:0] STAT_RST = 16'h0000;
    localparam int ABORT_WAIT_CYC = 5;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_T_CLAIM = 3'b001,
        ST_T_DATA = 3'b010,
        ST_T_TURN = 3'b011,
        ST_I_ADDR = 3'b100,
        ST_I_DATA = 3'b101,
        ST_I_TURN = 3'b110
    } port_state_t;
endpackage

// File: core/bus_parity.sv
// Even parity generator and one-clock-late checker for the address/data bus
module bus_parity
    import pbp_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [AD_W-1:0] ad_i,
    input wire logic [CBE_W-1:0] cbe_i,
    input wire logic ad_oe_n,
    input wire logic check,
    input wire logic par_i,
    output logic par_o,
    output logic par_oe_n,
    output logic mismatch
);
    logic par_ff;
    logic oe_n_ff;
    logic chk_ff;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            par_ff <= 1'b0;
            oe_n_ff <= 1'b1;
            chk_ff <= 1'b0;
        end else begin
            par_ff <= ^{ad_i, cbe_i};
            oe_n_ff <= ad_oe_n;
            chk_ff <= check;
        end
    end

    assign par_o = par_ff;
    // Released immediately in reset so the pin never holds a stale drive
    assign par_oe_n = oe_n_ff | sys_rst;
    assign mismatch = chk_ff & (par_i != par_ff);
endmodule

// File: core/primary_bus_bridge_port.sv
// Primary-side bus port of the bridge: target, initiator, parity, errors, reset
// Function
// - In reset every output floats, registers clear; default state after release. The code drives req_n_o high and loads hold_ff from the strap instead.
// - Secondary interface signals are driven low throughout primary reset.
// - All primary bus signals are sampled on the rising clock edge.
// - Address/data lines carry address in address phase, data in data phases.
// - Command/enable lines carry command, then byte enables; bit n covers lane n.
// - As target, claim a cycle by asserting device select.
// - As initiator, abort when no device select arrives before time-out.
// - Initiator asserts frame to start, deasserts it for the final data phase.
// - Request the bus by asserting the request output.
// - Answer configuration accesses only when the select input is high.
// - A data phase completes only when initiator and target ready both assert.
// - As initiator, use lock to gain exclusive access to the bus.
// - Compute even parity over address/data and command/enable lines.
// - Drive the parity bit one clock after the data it covers.
// - As target, compare computed parity with the initiator's parity bit.
// - Report parity errors only when command register bit 6 is set.
// - Pulse system error when enabled in the command register.
// - Bridge control bit 6 forwards downstream system errors to system error.
// - Targets may stop a transaction; the initiator honours it.
// - Hold strap high in reset asserts secondary reset and stops its clocks.
// - Secondary reset is primary reset OR the secondary-reset control bit OR the latched hold strap.
module primary_bus_bridge_port
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [pbp_pkg::AD_W-1:0] ad_i,
    output logic [pbp_pkg::AD_W-1:0] ad_o,
    output logic ad_oe_n,
    input wire logic [pbp_pkg::CBE_W-1:0] cbe_n_i,
    output logic [pbp_pkg::CBE_W-1:0] cbe_n_o,
    output logic cbe_n_oe_n,
    input wire logic par_i,
    output logic par_o,
    output logic par_oe_n,
    input wire logic frame_n_i,
    output logic frame_n_o,
    output logic frame_n_oe_n,
    input wire logic irdy_n_i,
    output logic irdy_n_o,
    output logic irdy_n_oe_n,
    input wire logic trdy_n_i,
    output logic trdy_n_o,
    output logic trdy_n_oe_n,
    input wire logic stop_n_i,
    output logic stop_n_o,
    output logic stop_n_oe_n,
    input wire logic devsel_n_i,
    output logic devsel_n_o,
    output logic devsel_n_oe_n,
    input wire logic lock_n_i,
    output logic lock_n_o,
    output logic lock_n_oe_n,
    input wire logic perr_n_i,
    output logic perr_n_o,
    output logic perr_n_oe_n,
    output logic serr_n_o,
    output logic serr_n_oe_n,
    input wire logic clkrun_n_i,
    output logic clkrun_n_o,
    output logic clkrun_n_oe_n,
    output logic req_n_o,
    input wire logic gnt_n_i,
    input wire logic idsel,
    input wire logic hold_strap,
    input wire logic sys_err_evt,
    input wire logic sec_serr_evt,
    output logic sec_drive_low,
    output logic sec_bus_rst,
    output logic sec_clk_stop,
    input wire logic init_req,
    input wire logic init_write,
    input wire logic init_lock,
    input wire logic [3:0] init_cmd,
    input wire logic [pbp_pkg::AD_W-1:0] init_addr,
    input wire logic [pbp_pkg::AD_W-1:0] init_wdata,
    input wire logic [pbp_pkg::CBE_W-1:0] init_be,
    output logic init_done,
    output logic init_abort,
    output logic init_retry,
    output logic [pbp_pkg::AD_W-1:0] init_rdata
);
    import pbp_pkg::*;
    port_state_t state_ff, nxt_state;
    logic [AD_W-1:0] ad_ff;
    logic [CBE_W-1:0] cbe_ff;
    logic [IDX_W-1:0] idx_ff;
    logic t_rd_ff, idle_q_ff;
    logic [2:0] cnt_ff;
    logic [15:0] cmd_ff, bctl_ff, stat_ff;
    logic [15:0] nxt_stat;
    logic hold_ff, lock_held_ff, clkrun_drv_ff;
    logic serr_ff, perr_ff, perr_rel_ff;
    logic done_ff, abort_ff, retry_ff;
    logic [AD_W-1:0] rdata_ff;

    // Sampled bus conditions, all taken at the rising edge
    wire frame = ~frame_n_i;
    wire irdy = ~irdy_n_i;
    wire trdy = ~trdy_n_i;
    wire stop = ~stop_n_i;
    wire devsel = ~devsel_n_i;
    wire [3:0] be = ~cbe_n_i;
    wire bus_idle = frame_n_i & irdy_n_i;
    wire addr_phase = frame & idle_q_ff;
    wire cfg_cmd = (cbe_n_i == CMD_CFG_RD) | (cbe_n_i == CMD_CFG_WR);
    wire t_hit = addr_phase & idsel & cfg_cmd & (ad_i[1:0] == 2'b00);
    wire st_idle = state_ff == ST_IDLE;
    wire st_tc = state_ff == ST_T_CLAIM;
    wire st_td = state_ff == ST_T_DATA;
    wire st_tt = state_ff == ST_T_TURN;
    wire st_ia = state_ff == ST_I_ADDR;
    wire st_id = state_ff == ST_I_DATA;
    wire st_it = state_ff == ST_I_TURN;
    wire t_xfer = st_td & irdy;
    wire i_xfer = st_id & trdy;
    wire i_stop = st_id & stop & ~trdy;
    wire i_abort = st_id & ~devsel & (cnt_ff == 3'(ABORT_WAIT_CYC - 1));
    wire i_end = i_xfer | i_stop | i_abort;
    wire i_go = st_idle & ~t_hit & init_req & ~gnt_n_i & bus_idle;
    wire wr_hit = t_xfer & ~t_rd_ff;
    wire idx_cmd = idx_ff == CFG_IDX_CMD;
    wire idx_bctl = idx_ff == CFG_IDX_BCTL;
    wire [AD_W-1:0] cfg_rdata = idx_cmd ? {stat_ff, cmd_ff} :
                                idx_bctl ? {bctl_ff, 16'h0000} : 32'h0000_0000;
    wire par_err;
    wire par_check = wr_hit | (i_xfer & ~init_write);
    wire [15:0] w1c = (wr_hit & idx_cmd) ?
        {ad_i[31:24] & {8{be[3]}}, ad_i[23:16] & {8{be[2]}}} : 16'h0000;
    wire [15:0] stat_set = {par_err, serr_ff, i_abort, 13'h0000} & STAT_MASK;
    wire serr_fire = (cmd_ff[CMD_SERR_EN_BIT] & sys_err_evt) |
                     (bctl_ff[BCTL_SERR_FWD_BIT] & sec_serr_evt);
    wire busy = ~st_idle | init_req;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (t_hit) begin
                    nxt_state = ST_T_CLAIM;
                end else if (i_go) begin
                    nxt_state = ST_I_ADDR;
                end
            end
            ST_T_CLAIM: nxt_state = ST_T_DATA;
            ST_T_DATA: begin
                if (irdy) begin
                    nxt_state = ST_T_TURN;
                end
            end
            ST_T_TURN: nxt_state = ST_IDLE;
            ST_I_ADDR: nxt_state = ST_I_DATA;
            ST_I_DATA: begin
                if (i_end) begin
                    nxt_state = ST_I_TURN;
                end
            end
            ST_I_TURN: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // Stickies: a hardware set in the clearing cycle survives
    assign nxt_stat = (stat_ff & ~w1c) | stat_set;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
            idle_q_ff <= 1'b1;
            cnt_ff <= 3'd0;
            idx_ff <= '0;
            t_rd_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            idle_q_ff <= bus_idle;
            cnt_ff <= st_id ? cnt_ff + 3'd1 : 3'd0;
            if (t_hit) begin
                idx_ff <= ad_i[7:2];
                t_rd_ff <= cbe_n_i == CMD_CFG_RD;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cmd_ff <= CMD_RST;
            bctl_ff <= BCTL_RST;
            stat_ff <= STAT_RST;
        end else begin
            stat_ff <= nxt_stat;
            if (wr_hit & idx_cmd & be[0]) begin
                cmd_ff[7:0] <= ad_i[7:0];
            end
            if (wr_hit & idx_cmd & be[1]) begin
                cmd_ff[15:8] <= ad_i[15:8];
            end
            if (wr_hit & idx_bctl & be[2]) begin
                bctl_ff[7:0] <= ad_i[23:16];
            end
            if (wr_hit & idx_bctl & be[3]) begin
                bctl_ff[15:8] <= ad_i[31:24];
            end
        end
    end

    // Drive data: address first, then write data or read-back
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ad_ff <= '0;
            cbe_ff <= '1;
        end else if (nxt_state == ST_I_ADDR) begin
            ad_ff <= init_addr;
            cbe_ff <= init_cmd;
        end else if (nxt_state == ST_I_DATA) begin
            ad_ff <= init_wdata;
            cbe_ff <= ~init_be;
        end else if (st_tc) begin
            ad_ff <= cfg_rdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            done_ff <= 1'b0;
            abort_ff <= 1'b0;
            retry_ff <= 1'b0;
            rdata_ff <= '0;
            lock_held_ff <= 1'b0;
            serr_ff <= 1'b0;
            perr_ff <= 1'b0;
            perr_rel_ff <= 1'b0;
            clkrun_drv_ff <= 1'b0;
        end else begin
            done_ff <= i_end;
            abort_ff <= i_abort;
            retry_ff <= i_stop;
            if (i_xfer & ~init_write) begin
                rdata_ff <= ad_i;
            end
            if (~init_lock) begin
                lock_held_ff <= 1'b0;
            end else if (i_xfer) begin
                lock_held_ff <= 1'b1;
            end
            serr_ff <= serr_fire;
            perr_ff <= par_err & cmd_ff[CMD_PERR_EN_BIT];
            perr_rel_ff <= perr_ff;
            clkrun_drv_ff <= busy & (clkrun_n_i | clkrun_drv_ff);
        end
    end

    // Strap is caught while reset is held and kept after release
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hold_ff <= hold_strap;
        end
    end

    bus_parity u_parity (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .ad_i(ad_i),
        .cbe_i(cbe_n_i),
        .ad_oe_n(ad_oe_n),
        .check(par_check),
        .par_i(par_i),
        .par_o(par_o),
        .par_oe_n(par_oe_n),
        .mismatch(par_err)
    );

    assign ad_o = ad_ff;
    assign cbe_n_o = cbe_ff;
    assign ad_oe_n = sys_rst | ~(st_ia | (st_id & init_write) | (st_td & t_rd_ff));
    assign cbe_n_oe_n = sys_rst | ~(st_ia | st_id);
    assign frame_n_o = ~st_ia;
    assign frame_n_oe_n = sys_rst | ~(st_ia | st_id);
    assign irdy_n_o = ~st_id;
    assign irdy_n_oe_n = sys_rst | ~(st_id | st_it);
    assign devsel_n_o = ~(st_tc | st_td);
    assign devsel_n_oe_n = sys_rst | ~(st_tc | st_td | st_tt);
    // Single-phase target: ready and disconnect together stop any burst
    assign trdy_n_o = ~st_td;
    assign trdy_n_oe_n = sys_rst | ~(st_tc | st_td | st_tt);
    assign stop_n_o = ~st_td;
    assign stop_n_oe_n = sys_rst | ~(st_tc | st_td | st_tt);
    assign lock_n_o = 1'b0;
    assign lock_n_oe_n = sys_rst | ~(lock_held_ff | (init_lock & st_id));
    assign perr_n_o = ~perr_ff;
    assign perr_n_oe_n = sys_rst | ~(perr_ff | perr_rel_ff);
    assign serr_n_o = 1'b0;
    assign serr_n_oe_n = sys_rst | ~serr_ff;
    // Drive holds itself while busy, so our own pull-down seen on the pin cannot release it
    assign clkrun_n_o = 1'b0;
    assign clkrun_n_oe_n = sys_rst | ~clkrun_drv_ff;
    assign req_n_o = sys_rst | ~(st_idle & init_req);
    assign sec_drive_low = sys_rst;
    assign sec_bus_rst = sys_rst | bctl_ff[BCTL_SEC_RST_BIT] | hold_ff;
    assign sec_clk_stop = hold_ff;
    assign init_done = done_ff;
    assign init_abort = abort_ff;
    assign init_retry = retry_ff;
    assign init_rdata = rdata_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (1'b0);

    a_reset_float: assert property (sys_rst |-> ad_oe_n && frame_n_oe_n
        && devsel_n_oe_n && serr_n_oe_n && req_n_o) else $error("output driven in reset");
    a_sec_low: assert property (sys_rst |-> sec_drive_low && sec_bus_rst)
        else $error("secondary not held in reset");
    a_claim_next: assert property (disable iff (sys_rst)
        t_hit && st_idle |=> !devsel_n_oe_n && !devsel_n_o ##1 !trdy_n_o)
        else $error("target claim missing");
    a_abort_bound: assert property (disable iff (sys_rst)
        $rose(st_id) ##0 (st_id && devsel_n_i)[*5] |=> init_abort) else $error("no abort");
    a_frame_final: assert property (disable iff (sys_rst)
        st_ia |=> frame_n_o && !irdy_n_o && !frame_n_oe_n) else $error("frame not released");
    a_req_idle: assert property (disable iff (sys_rst)
        !req_n_o && !gnt_n_i && bus_idle && !t_hit |=> !frame_n_o) else $error("grant ignored");
    a_done_ready: assert property (disable iff (sys_rst)
        init_done && !init_abort && !init_retry |-> $past(!irdy_n_i && !trdy_n_i))
        else $error("done without both ready");
    a_par_delay: assert property (disable iff (sys_rst)
        !ad_oe_n |=> !par_oe_n && (par_o == ^{$past(ad_i), $past(cbe_n_i)}))
        else $error("parity late or wrong");
    a_perr_gate: assert property (disable iff (sys_rst)
        !perr_n_oe_n && !perr_n_o |-> $past(cmd_ff[CMD_PERR_EN_BIT], 1))
        else $error("parity error while disabled");
    a_serr_cause: assert property (disable iff (sys_rst)
        !serr_n_oe_n |-> $past(serr_fire)) else $error("system error without cause");
    c_target_wr: cover property (disable iff (sys_rst) wr_hit);
    c_init_done: cover property (disable iff (sys_rst) i_xfer);
    c_init_abort: cover property (disable iff (sys_rst) i_abort);
    c_init_retry: cover property (disable iff (sys_rst) i_stop);
endmodule

// File: testbench/bus_agent.sv
// Far-side agent model: primary arbiter plus a one-phase memory target
module bus_agent (
    input wire logic core_clk,
    input wire logic req_n,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic par,
    input wire logic [31:0] ad,
    input wire logic [3:0] cbe_n,
    input wire logic [1:0] mode,
    input wire logic [31:0] rdata,
    output logic gnt_n,
    output logic ctl_oe,
    output logic devsel_n,
    output logic trdy_n,
    output logic stop_n,
    output logic ad_oe,
    output logic [31:0] ad_o,
    output logic par_oe,
    output logic par_o,
    output logic [31:0] addr,
    output logic [31:0] data,
    output logic [3:0] be_n,
    output logic par_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fr_q;
    logic rd;
    int ph;
    initial begin
        {gnt_n, devsel_n, trdy_n, stop_n, fr_q} = '1;
        {ctl_oe, ad_oe, par_oe, rd, par_o} = '0;
        ph = 0;
    end
    // Mode 1 never claims, mode 2 stops without data, mode 3 corrupts read parity
    always @(posedge core_clk) begin
        gnt_n <= req_n;
        fr_q <= frame_n;
        par_oe <= ad_oe;
        par_o <= ^{ad, cbe_n} ^ (mode == 2'h3);
        case (ph)
            0: if (fr_q && !frame_n && cbe_n[3:1] != 3'h5 && mode != 2'h1) begin
                addr <= ad;
                rd <= !cbe_n[0];
                ctl_oe <= 1'h1;
                ph <= 1;
            end
            1: begin
                devsel_n <= 1'h0;
                ph <= 2;
            end
            2: begin
                trdy_n <= mode == 2'h2;
                stop_n <= mode != 2'h2;
                ad_oe <= rd;
                ad_o <= rdata;
                ph <= 3;
            end
            3: if (!irdy_n) begin
                data <= ad;
                be_n <= cbe_n;
                {devsel_n, trdy_n, stop_n} <= 3'h7;
                ad_oe <= 1'h0;
                ph <= 4;
            end
            default: begin
                par_seen <= par;
                ctl_oe <= 1'h0;
                ph <= 0;
            end
        endcase
    end
endmodule

// File: testbench/tb.sv
// Self-checking bench for the primary bridge port
module tb;
    import pbp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic h_frame = 1'h1, h_irdy = 1'h1, h_par = 1'h0, badp = 1'h0, idsel = 1'h0;
    logic hold_strap = 1'h1, sys_err_evt = 1'h0, sec_serr_evt = 1'h0, init_req = 1'h0;
    logic init_write = 1'h0, init_lock = 1'h0;
    logic [3:0] h_cbe = 4'hF, init_cmd = 4'h0, init_be = 4'h5;
    logic [31:0] h_ad = 32'h0, init_addr = 32'h0, init_wdata = 32'hA5C3_0F96;
    logic [1:0] mode = 2'h0;
    int miscompares = 0, total_checks = 0;
    logic [31:0] ad_o, init_rdata, p_ad, p_addr, p_data;
    logic [3:0] cbe_n_o, p_be;
    logic ad_oe_n, cbe_n_oe_n, par_o, par_oe_n, frame_n_o, frame_n_oe_n, irdy_n_o, irdy_n_oe_n;
    logic trdy_n_o, trdy_n_oe_n, stop_n_o, stop_n_oe_n, devsel_n_o, devsel_n_oe_n, lock_n_o;
    logic lock_n_oe_n, perr_n_o, perr_n_oe_n, serr_n_o, serr_n_oe_n, clkrun_n_oe_n, req_n_o;
    logic sec_drive_low, sec_bus_rst, sec_clk_stop, init_done, init_abort, init_retry;
    logic gnt, p_oe, p_dv, p_tr, p_st, p_ad_oe, p_par_oe, p_par, p_pseen, clkrun_n_o;
    wire logic [31:0] ad = !ad_oe_n ? ad_o : p_ad_oe ? p_ad : h_ad;
    wire logic [3:0] cbe = !cbe_n_oe_n ? cbe_n_o : h_cbe;
    wire logic par = !par_oe_n ? par_o : p_par_oe ? p_par : h_par;
    wire logic frame = frame_n_oe_n ? h_frame : frame_n_o;
    wire logic irdy = irdy_n_oe_n ? h_irdy : irdy_n_o;
    // Released control lines float up to their pull-up level
    wire logic trdy = trdy_n_oe_n ? !p_oe | p_tr : trdy_n_o;
    wire logic stop = stop_n_oe_n ? !p_oe | p_st : stop_n_o;
    wire logic devsel = devsel_n_oe_n ? !p_oe | p_dv : devsel_n_o;
    wire logic lock = lock_n_oe_n | lock_n_o;
    wire logic perr = perr_n_oe_n | perr_n_o;
    wire logic serr = serr_n_oe_n | serr_n_o;
    wire logic clkrun = clkrun_n_oe_n | clkrun_n_o;

    primary_bus_bridge_port primary_bus_bridge_port_inst (
        .core_clk, .sys_rst, .ad_i(ad), .ad_o, .ad_oe_n, .cbe_n_i(cbe), .cbe_n_o, .cbe_n_oe_n,
        .par_i(par), .par_o, .par_oe_n, .frame_n_i(frame), .frame_n_o, .frame_n_oe_n,
        .irdy_n_i(irdy), .irdy_n_o, .irdy_n_oe_n, .trdy_n_i(trdy), .trdy_n_o, .trdy_n_oe_n,
        .stop_n_i(stop), .stop_n_o, .stop_n_oe_n, .devsel_n_i(devsel), .devsel_n_o,
        .devsel_n_oe_n, .lock_n_i(lock), .lock_n_o, .lock_n_oe_n, .perr_n_i(perr), .perr_n_o,
        .perr_n_oe_n, .serr_n_o, .serr_n_oe_n, .clkrun_n_i(clkrun), .clkrun_n_o,
        .clkrun_n_oe_n, .req_n_o, .gnt_n_i(gnt), .idsel, .hold_strap, .sys_err_evt,
        .sec_serr_evt, .sec_drive_low, .sec_bus_rst, .sec_clk_stop, .init_req, .init_write,
        .init_lock, .init_cmd, .init_addr, .init_wdata, .init_be, .init_done, .init_abort,
        .init_retry, .init_rdata
    );
    bus_agent bus_agent_inst (
        .core_clk, .req_n(req_n_o), .frame_n(frame), .irdy_n(irdy), .par, .ad, .cbe_n(cbe),
        .mode, .rdata(32'h0F1E_2D3C), .gnt_n(gnt), .ctl_oe(p_oe), .devsel_n(p_dv),
        .trdy_n(p_tr), .stop_n(p_st), .ad_oe(p_ad_oe), .ad_o(p_ad), .par_oe(p_par_oe),
        .par_o(p_par), .addr(p_addr), .data(p_data), .be_n(p_be), .par_seen(p_pseen)
    );

    initial forever #5 core_clk = ~core_clk;
    // Host parity trails its address/data by one clock; badp corrupts it
    always @(posedge core_clk) h_par <= ^{h_ad, h_cbe} ^ badp;

    task automatic summarize;
        if (miscompares == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [35:0] g, e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic rst(input logic strap);
        @(negedge core_clk);
        sys_rst = 1'h1;
        hold_strap = strap;
        repeat (8) @(negedge core_clk);
        chk({ad_oe_n, cbe_n_oe_n, par_oe_n, frame_n_oe_n, irdy_n_oe_n, trdy_n_oe_n, stop_n_oe_n,
             devsel_n_oe_n, lock_n_oe_n, perr_n_oe_n, serr_n_oe_n, clkrun_n_oe_n, req_n_o,
             sec_drive_low, sec_bus_rst}, 36'h7FFF);
        sys_rst = 1'h0;
        hold_strap = 1'h0;
        @(negedge core_clk);
        chk({sec_drive_low, sec_bus_rst, sec_clk_stop}, {1'h0, strap, strap});
    endtask

    // Host configuration access, one data phase; got reports a claim with data
    task automatic cfg(input logic wr, sel, input logic [5:0] idx, input logic [31:0] d,
                       input logic [3:0] be, output logic got, output logic [31:0] q);
        got = 1'h0;
        repeat (2) @(negedge core_clk);
        idsel = sel;
        h_frame = 1'h0;
        h_ad = {24'h0, idx, 2'h0};
        h_cbe = wr ? CMD_CFG_WR : CMD_CFG_RD;
        @(negedge core_clk);
        idsel = 1'h0;
        h_frame = 1'h1;
        h_irdy = 1'h0;
        h_ad = d;
        h_cbe = ~be;
        for (int n = 0; n < 6 && !got; n++) begin
            @(negedge core_clk);
            got = !trdy && !devsel && !stop;
            q = ad;
        end
        @(negedge core_clk);
        h_irdy = 1'h1;
        h_ad = ~h_ad;
        if (!wr && got) chk(par, ^{q, ~be});
        chk(got, sel);
    endtask

    task automatic seen(input logic s_perr, output logic s);
        s = 1'h0;
        repeat (5) begin
            @(posedge core_clk);
            sys_err_evt <= 1'h0;
            sec_serr_evt <= 1'h0;
            #1;
            s |= s_perr ? !perr : !serr;
        end
    endtask

    task automatic evt(input logic sec, input logic e);
        logic s;
        @(negedge core_clk);
        sys_err_evt = !sec;
        sec_serr_evt = sec;
        seen(1'h0, s);
        chk(s, e);
    endtask

    // Flags: {parity error, abort, retry, lock, clock-run}
    task automatic ini(input logic wr, lk, input logic [1:0] md, input logic [31:0] a,
                       output logic [4:0] fl);
        fl = 5'h0;
        @(negedge core_clk);
        mode = md;
        init_write = wr;
        init_lock = lk;
        init_cmd = wr ? 4'h7 : 4'h6;
        init_addr = a;
        init_req = 1'h1;
        for (int n = 0; n < 30 && init_done !== 1'h1; n++) begin
            @(posedge core_clk);
            #1;
            fl |= {!perr, init_abort, init_retry, !lock, !clkrun};
        end
        if (init_done !== 1'h1) begin
            miscompares++;
            summarize();
        end
        @(negedge core_clk);
        init_req = 1'h0;
        init_lock = 1'h0;
        repeat (3) begin
            @(posedge core_clk);
            #1;
            fl[4] |= !perr;
        end
    endtask

    initial begin
        logic g;
        logic [31:0] q;
        logic [4:0] f;
        rst(1'h1);
        rst(1'h0);
        evt(1'h0, 1'h0);
        cfg(1'h1, 1'h0, CFG_IDX_CMD, 32'h0000_0140, 4'hF, g, q);
        chk(g, 1'h0);
        badp = 1'h1;
        cfg(1'h1, 1'h1, CFG_IDX_BCTL, 32'h0060_0000, 4'hC, g, q);
        seen(1'h1, g);
        badp = 1'h0;
        chk({g, sec_bus_rst}, 2'h1);
        cfg(1'h0, 1'h1, CFG_IDX_CMD, 32'h0, 4'hF, g, q);
        chk(q, 32'h8000_0000);
        cfg(1'h1, 1'h1, CFG_IDX_CMD, 32'h8000_0140, 4'hF, g, q);
        cfg(1'h1, 1'h1, CFG_IDX_CMD, 32'hFFFF_FFFF, 4'h4, g, q);
        cfg(1'h0, 1'h1, CFG_IDX_CMD, 32'h0, 4'hF, g, q);
        chk(q, 32'h0000_0140);
        cfg(1'h0, 1'h1, 6'h02, 32'h0, 4'hF, g, q);
        chk(q, 32'h0);
        badp = 1'h1;
        cfg(1'h1, 1'h1, CFG_IDX_BCTL, 32'h0040_0000, 4'hC, g, q);
        seen(1'h1, g);
        badp = 1'h0;
        chk({g, sec_bus_rst}, 2'h2);
        evt(1'h1, 1'h1);
        evt(1'h0, 1'h1);
        ini(1'h1, 1'h1, 2'h0, 32'h1000_0040, f);
        chk(f, 5'h03);
        chk(p_addr, 32'h1000_0040);
        chk({p_data, p_be}, {init_wdata, ~init_be});
        chk(p_pseen, ^{init_wdata, ~init_be});
        ini(1'h0, 1'h0, 2'h3, 32'h1000_0080, f);
        chk(f, 5'h11);
        chk(init_rdata, 32'h0F1E_2D3C);
        ini(1'h0, 1'h0, 2'h1, 32'h2000_0000, f);
        chk(f, 5'h09);
        ini(1'h1, 1'h0, 2'h2, 32'h1000_0010, f);
        chk(f, 5'h05);
        rst(1'h0);
        cfg(1'h0, 1'h1, CFG_IDX_CMD, 32'h0, 4'hF, g, q);
        chk(q, 32'h0);
        summarize();
    end
endmodule
